/* File: rxfp_chk_sva.sv */
// Checker on the client stream and pause ports of the frame processor.
// Assumes binding to rxfp_rx_mac; parameters are passed through.
`timescale 1ns/100ps
`default_nettype none
module rxfp_chk #(parameter EOP_ALIGN = 1, parameter FLOW_MODE = 0) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic srst_in,
   // Client stream
   input wire logic rx_valid_out,
   input wire logic rx_sop_out,
   input wire logic rx_eop_out,
   input wire logic [1:0] rx_error_out,
   input wire logic rx_fcs_error_out,
   input wire logic rx_fcs_valid_out,
   input wire logic [2:0] rx_ctrl_kind_out,
   // Pause requests
   input wire logic pause_std_out,
   input wire logic pfc_req_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);
   logic in_pkt;
   ////////////////////////////////////////
   // Open packet tracker, so a stray second end shows up
   always @(posedge clk_in) begin
      if (srst_in)
         in_pkt <= 1'b0;
      else if (rx_valid_out)
         in_pkt <= (in_pkt | rx_sop_out) & ~rx_eop_out;
   end
   sequence s_checked_end;
      rx_eop_out && rx_valid_out;
   endsequence
   a_sop_valid: assert property (rx_sop_out |-> rx_valid_out && !in_pkt)
      else $error("start outside idle or without valid");
   a_eop_in_pkt: assert property (rx_eop_out |-> rx_valid_out && (in_pkt || rx_sop_out))
      else $error("end of packet without open packet");
   a_fcs_qualified: assert property (rx_fcs_error_out |-> rx_fcs_valid_out && rx_error_out[1])
      else $error("checksum error without valid or error bit");
   a_err1_from_fcs: assert property (rx_error_out[1] |-> rx_fcs_error_out)
      else $error("error bit 1 without checksum error");
   a_fcs_on_eop: assert property ((EOP_ALIGN != 0) && rx_fcs_valid_out |-> s_checked_end)
      else $error("checksum status off the end cycle");
   a_malformed_end: assert property (rx_error_out[0] |-> rx_eop_out && rx_fcs_error_out)
      else $error("malformed flag without end and checksum error");
   a_kind_onehot: assert property (rx_valid_out |-> $onehot0(rx_ctrl_kind_out))
      else $error("control kind not one-hot");
   a_kind_held: assert property (rx_valid_out && in_pkt |-> $stable(rx_ctrl_kind_out))
      else $error("control kind changed inside packet");
   a_no_pause: assert property ((FLOW_MODE == 0) |-> !pause_std_out && !pfc_req_out)
      else $error("pause acted with flow control off");
endmodule // rxfp_chk
bind rxfp_rx_mac rxfp_chk #(.EOP_ALIGN(EOP_ALIGN), .FLOW_MODE(FLOW_MODE)) u_chk (
   .clk_in(clk_in), .srst_in(srst_in), .rx_valid_out(rx_valid_out), .rx_sop_out(rx_sop_out),
   .rx_eop_out(rx_eop_out), .rx_error_out(rx_error_out), .rx_fcs_error_out(rx_fcs_error_out),
   .rx_fcs_valid_out(rx_fcs_valid_out), .rx_ctrl_kind_out(rx_ctrl_kind_out),
   .pause_std_out(pause_std_out), .pfc_req_out(pfc_req_out)
);
`default_nettype wire

/* File: rxfp_consts.vh */
// Constants of the receive frame processor: codes, offsets, fields, reset values.
// Assumes a link word of control-flagged bytes with lane 0 in the top byte.
//
// Overview of operation
// - Accept a frame only after Start, six preamble bytes, then delimiter.
// - Start byte counts only on lane 0, the top byte of the word.
// - Byte d5 is the delimiter closing the preamble.
// - Strip preamble and gap bytes unless preamble passthrough is built in.
// - Config bit 0 strips the checksum, default on, for any bus width.
// - End marker sits on last checksum byte, or last payload byte when stripped.
// - Kept checksum bytes follow the last data byte directly.
// - Checksum error comes with its valid flag and error bit 1.
// - Aligned option puts checksum error on end cycle, else one cycle later.
// - Checksum is taken least significant bit first, top coefficient first.
// - A terminate character at frame end produces end of packet.
// - Error character ends frame as malformed with checksum error; no second end.
// - Any other control character ends frame likewise; later terminate ignored.
// - Frames with injected transmit errors count as malformed.
// - Gap bytes dropped on the wide stream, passed on the custom stream; here only whole idle words pass, gap bytes sharing a frame word are lost.
// - Reed-Solomon option adds marker lock, decoder and transcoding upstream.
// - Pause frames act only in flow modes with their enable bits set.
// - With no flow control built in, pause frames never act.
// - Control frames not matching the mode pass through unchanged.
// - Three-bit one-hot control kind flag; zero means ordinary frame.
// - Client bus is 256 bits custom or 512 bits standard.
// - Start of packet always in the top byte; valid qualifies outputs.
// - At end of packet a 6-bit count gives unused low bytes.
// - All client signals are synchronous to the receive clock.
`ifndef RXFP_CONSTS_VH
`define RXFP_CONSTS_VH

`define RXFP_START 8'hfb
`define RXFP_TERM 8'hfd
`define RXFP_PRE 8'h55
`define RXFP_SFD 8'hd5
`define RXFP_PRE_LEN 8
`define RXFP_FCS_LEN 4
`define RXFP_CRC_INIT 32'hffffffff
`define RXFP_CRC_POLY 32'hedb88320
`define RXFP_CRC_RESIDUE 32'hdebb20e3
`define RXFP_ETYPE_CTRL 16'h8808
`define RXFP_OP_STD 16'h0001
`define RXFP_OP_PFC 16'h0101
`define RXFP_TYPE_POS 12
`define RXFP_OP_POS 14
`define RXFP_PARAM_POS 16
`define RXFP_FLOW_NONE 0
`define RXFP_FLOW_STD 1
`define RXFP_FLOW_PFC 2
`define RXFP_REG_STRIP 4'h0
`define RXFP_REG_PAUSE 4'h4
`define RXFP_REG_STAT 4'h8
`define RXFP_STRIP_BIT 0
`define RXFP_STD_EN_BIT 0
`define RXFP_PFC_EN_LSB 1
`define RXFP_FWD_BIT 16
`define RXFP_STRIP_RST 1'h1
`define RXFP_STD_EN_RST 1'h1
`define RXFP_PFC_EN_RST 8'hff
`define RXFP_FWD_RST 1'h0
`define RXFP_KIND_STD 3'h1
`define RXFP_KIND_PFC 3'h2
`define RXFP_KIND_OTHER 3'h4

`endif

/* File: rxfp_rx_mac.v */
// Receive frame processor: preamble check, checksum strip and check, malformed
// ends, pause handling and control-frame tagging toward the client stream.
// Assumes link words arrive every clock from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "rxfp_consts.vh"

module rxfp_rx_mac #(
   parameter DATA_BYTES = 64,
   parameter PREAMBLE_PASS = 0,
   parameter EOP_ALIGN = 1,
   parameter FLOW_MODE = 0,
   parameter CUSTOM_IF = 0,
   parameter REED_SOLOMON_OPTION = 0
) (
   // Clock and reset
   input wire clk_in,
   input wire srst_in,
   // Link side, one control flag per byte
   input wire [8*DATA_BYTES-1:0] lnk_data_in,
   input wire [DATA_BYTES-1:0] lnk_ctrl_in,
   // Register port
   input wire [3:0] reg_addr_in,
   input wire [31:0] reg_wdata_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   output reg [31:0] reg_rdata_out,
   // Client stream
   output reg [8*DATA_BYTES-1:0] rx_data_out,
   output reg rx_valid_out,
   output reg rx_sop_out,
   output reg rx_eop_out,
   output reg [5:0] rx_empty_out,
   output reg [1:0] rx_error_out,
   output reg rx_fcs_error_out,
   output reg rx_fcs_valid_out,
   output reg [2:0] rx_ctrl_kind_out,
   // Pause requests toward transmit side
   output reg pause_std_out,
   output reg [15:0] pause_quanta_out,
   output reg pfc_req_out,
   output reg [7:0] pfc_class_out
);

localparam W = DATA_BYTES;
localparam DW = 8 * DATA_BYTES;
localparam [6:0] WB = DATA_BYTES;
localparam SH = PREAMBLE_PASS ? 0 : `RXFP_PRE_LEN;
localparam [6:0] SHB = SH;
localparam BASE = PREAMBLE_PASS ? `RXFP_PRE_LEN : 0;
localparam [6:0] FCSB = `RXFP_FCS_LEN;
localparam [2:0] ST_IDLE = 3'h1;
localparam [2:0] ST_FRAME = 3'h2;
localparam [2:0] ST_DROP = 3'h4;

////////////////////////////////////////////////////////////////////////////////
// Helpers

function [7:0] lane;
   input [DW-1:0] d;
   input integer i;
   begin
      lane = d[DW-8-8*i +: 8];
   end
endfunction

// Lowest lane holding a control byte at or above lo, W when none
function [6:0] first_ctrl;
   input [W-1:0] c;
   input integer lo;
   integer i;
   begin
      first_ctrl = WB;
      for (i = W - 1; i >= lo; i = i - 1) begin
         if (c[W-1-i]) begin
            first_ctrl = i[6:0];
         end
      end
   end
endfunction

// Reflected update: bit 0 of each byte first, so the top coefficient leads
function [31:0] crc_upd;
   input [31:0] c;
   input [DW-1:0] d;
   input [6:0] n;
   input [6:0] lo;
   integer i, b;
   reg [31:0] r;
   reg [7:0] x;
   begin
      r = c;
      for (i = 0; i < W; i = i + 1) begin
         x = d[DW-8-8*i +: 8];
         if (i[6:0] >= lo && i[6:0] < n) begin
            for (b = 0; b < 8; b = b + 1) begin
               r = (r[0] ^ x[b]) ? ((r >> 1) ^ `RXFP_CRC_POLY) : (r >> 1);
            end
         end
      end
      crc_upd = r;
   end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Registers

reg cfg_strip;
reg cfg_std_en;
reg [7:0] cfg_pfc_en;
reg cfg_fwd;
reg [7:0] cnt_malformed;
reg [7:0] cnt_fcs;
reg [2:0] st;

always @(posedge clk_in) begin
   if (srst_in) begin
      cfg_strip <= `RXFP_STRIP_RST;
      cfg_std_en <= `RXFP_STD_EN_RST;
      cfg_pfc_en <= `RXFP_PFC_EN_RST;
      cfg_fwd <= `RXFP_FWD_RST;
      reg_rdata_out <= 32'h0;
   end else begin
      if (reg_wr_in && reg_addr_in == `RXFP_REG_STRIP) begin
         cfg_strip <= reg_wdata_in[`RXFP_STRIP_BIT];
      end
      if (reg_wr_in && reg_addr_in == `RXFP_REG_PAUSE) begin
         cfg_std_en <= reg_wdata_in[`RXFP_STD_EN_BIT];
         cfg_pfc_en <= reg_wdata_in[`RXFP_PFC_EN_LSB +: 8];
         cfg_fwd <= reg_wdata_in[`RXFP_FWD_BIT];
      end
      reg_rdata_out <= 32'h0;
      if (reg_rd_in) begin
         case (reg_addr_in)
            `RXFP_REG_STRIP: reg_rdata_out <= {31'h0, cfg_strip};
            `RXFP_REG_PAUSE: reg_rdata_out <= {15'h0, cfg_fwd, 7'h0, cfg_pfc_en, cfg_std_en};
            // Option bit only reports the build; FEC sublayers sit ahead of the link port
            `RXFP_REG_STAT: reg_rdata_out <= {14'h0, REED_SOLOMON_OPTION != 0, st == ST_FRAME,
                                               cnt_fcs, cnt_malformed};
            default: reg_rdata_out <= 32'h0;
         endcase
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// Link word analysis

reg is_start;
reg pre_ok;
reg [6:0] ck0;
reg [6:0] ck8;
reg [2:0] next_st;
reg cur_in;
reg cur_sop;
reg [6:0] cur_lim;
reg [7:0] end_byte;
reg cur_bad;
integer k;

always @* begin
   is_start = lnk_ctrl_in[W-1] && lane(lnk_data_in, 0) == `RXFP_START;
   pre_ok = 1'b1;
   for (k = 1; k < `RXFP_PRE_LEN; k = k + 1) begin
      if (lnk_ctrl_in[W-1-k] || lane(lnk_data_in, k) != (k == 7 ? `RXFP_SFD : `RXFP_PRE)) begin
         pre_ok = 1'b0;
      end
   end
   ck0 = first_ctrl(lnk_ctrl_in, 0);
   ck8 = first_ctrl(lnk_ctrl_in, `RXFP_PRE_LEN);
   next_st = st;
   cur_in = 1'b0;
   cur_sop = 1'b0;
   cur_lim = ck0;
   case (st)
      ST_IDLE: begin
         if (is_start) begin
            cur_lim = ck8;
            if (pre_ok) begin
               cur_in = 1'b1;
               cur_sop = 1'b1;
               if (ck8 == WB) next_st = ST_FRAME;
            end else if (ck8 == WB) begin
               next_st = ST_DROP;
            end
         end
      end
      ST_FRAME: begin
         cur_in = 1'b1;
         if (ck0 != WB) next_st = ST_IDLE;
      end
      ST_DROP: begin
         if (ck0 != WB) next_st = ST_IDLE;
      end
      default: next_st = ST_IDLE;
   endcase
   end_byte = (cur_lim < WB) ? lane(lnk_data_in, cur_lim) : 8'h00;
   // Error, idle or start in place of terminate; injected errors land here too
   cur_bad = cur_in && cur_lim != WB && end_byte != `RXFP_TERM;
end

////////////////////////////////////////////////////////////////////////////////
// Hold stage and word assembly, shifting out the preamble when stripped

reg [DW-1:0] hold_data;
reg [6:0] hold_k;
reg hold_act;
reg hold_sop;
reg hold_bad;

always @(posedge clk_in) begin
   if (srst_in) begin
      st <= ST_IDLE;
      hold_data <= {DW{1'b0}};
      hold_k <= 7'h0;
      hold_act <= 1'b0;
      hold_sop <= 1'b0;
      hold_bad <= 1'b0;
   end else begin
      st <= next_st;
      hold_data <= lnk_data_in;
      hold_k <= cur_in ? cur_lim : 7'h0;
      hold_act <= cur_in;
      hold_sop <= cur_sop;
      hold_bad <= cur_bad;
   end
end

wire [2*DW-1:0] pair = {hold_data, lnk_data_in};
wire [DW-1:0] asm_data = pair[2*DW-1-8*SH -: DW];
wire [6:0] asm_cnt = (hold_k > SHB ? hold_k - SHB : 7'h0) +
                     (hold_k == WB ? (cur_lim < SHB ? cur_lim : SHB) : 7'h0);
wire asm_fin = hold_k < WB || cur_lim <= SHB;
wire asm_bad = hold_k < WB ? hold_bad : cur_bad;
wire asm_fire = hold_act && asm_cnt != 7'h0;

reg [DW-1:0] a_data;
reg [6:0] a_cnt;
reg a_v;
reg a_sop;
reg a_fin;
reg a_bad;

always @(posedge clk_in) begin
   if (srst_in) begin
      a_data <= {DW{1'b0}};
      a_cnt <= 7'h0;
      a_v <= 1'b0;
      a_sop <= 1'b0;
      a_fin <= 1'b0;
      a_bad <= 1'b0;
   end else begin
      a_data <= asm_data;
      a_cnt <= asm_cnt;
      a_v <= asm_fire;
      a_sop <= hold_sop;
      a_fin <= asm_fin;
      a_bad <= asm_bad;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Checksum, control kind and pause decisions on the assembled word

wire [15:0] f_type = {lane(a_data, BASE + `RXFP_TYPE_POS), lane(a_data, BASE + `RXFP_TYPE_POS + 1)};
wire [15:0] f_op = {lane(a_data, BASE + `RXFP_OP_POS), lane(a_data, BASE + `RXFP_OP_POS + 1)};
wire [15:0] f_par = {lane(a_data, BASE + `RXFP_PARAM_POS), lane(a_data, BASE + `RXFP_PARAM_POS + 1)};
wire [2:0] kind_c = f_type != `RXFP_ETYPE_CTRL ? 3'h0 :
                    f_op == `RXFP_OP_STD ? `RXFP_KIND_STD :
                    f_op == `RXFP_OP_PFC ? `RXFP_KIND_PFC : `RXFP_KIND_OTHER;

reg [31:0] crc_r;
reg [2:0] kind_r;
reg strip_r;
reg drop_r;
reg [15:0] par_r;

wire [2:0] f_kind = a_sop ? kind_c : kind_r;
wire f_strip = a_sop ? cfg_strip : strip_r;
wire [15:0] f_param = a_sop ? f_par : par_r;
// Matched pause frames act; mismatched kinds just pass through to the client
wire act_std = f_kind[0] && FLOW_MODE == `RXFP_FLOW_STD && cfg_std_en;
wire [7:0] pfc_cls = f_param[7:0] & cfg_pfc_en;
wire act_pfc = f_kind[1] && FLOW_MODE == `RXFP_FLOW_PFC && pfc_cls != 8'h0;
wire f_drop = a_sop ? ((act_std || act_pfc) && !cfg_fwd) : drop_r;
wire [6:0] skip = (a_sop && PREAMBLE_PASS != 0) ? 7'h8 : 7'h0;
wire [31:0] crc_n = crc_upd(a_sop ? `RXFP_CRC_INIT : crc_r, a_data, a_cnt, skip);
wire fcs_bad_now = a_bad || crc_n != `RXFP_CRC_RESIDUE;
// Tail of four or fewer bytes is pure checksum: fold the end into the word before
wire absorb = a_v && a_fin && f_strip && a_cnt <= FCSB;

always @(posedge clk_in) begin
   if (srst_in) begin
      crc_r <= `RXFP_CRC_INIT;
      kind_r <= 3'h0;
      strip_r <= `RXFP_STRIP_RST;
      drop_r <= 1'b0;
      par_r <= 16'h0;
      pause_std_out <= 1'b0;
      pause_quanta_out <= 16'h0;
      pfc_req_out <= 1'b0;
      pfc_class_out <= 8'h0;
   end else begin
      if (a_v) begin
         crc_r <= crc_n;
         kind_r <= f_kind;
         strip_r <= f_strip;
         drop_r <= f_drop;
         par_r <= f_param;
      end
      // Act only on a clean, complete pause frame
      pause_std_out <= a_v && a_fin && !fcs_bad_now && act_std;
      pfc_req_out <= a_v && a_fin && !fcs_bad_now && act_pfc;
      if (a_v && a_fin && !fcs_bad_now && act_std) pause_quanta_out <= f_param;
      if (a_v && a_fin && !fcs_bad_now && act_pfc) pfc_class_out <= pfc_cls;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Output stage: one word of look-behind so a stripped tail can move the end

reg [DW-1:0] b_data;
reg [6:0] b_cnt;
reg b_v;
reg b_sop;
reg b_fin;
reg b_bad;
reg b_fcs;
reg b_drop;
reg [2:0] b_kind;

wire emit = b_v && (b_fin || a_v);
wire eop_now = b_fin || absorb;
wire [6:0] kept = absorb ? b_cnt - (FCSB - a_cnt) : b_cnt;
wire fe_now = emit && eop_now && !b_drop && (b_fin ? b_fcs : fcs_bad_now);
wire bad_now = emit && eop_now && !b_drop && (b_fin ? b_bad : a_bad);
wire fv_now = emit && eop_now && !b_drop;
reg p_fe;
reg p_fv;

always @(posedge clk_in) begin
   if (srst_in) begin
      b_data <= {DW{1'b0}};
      b_cnt <= 7'h0;
      b_v <= 1'b0;
      b_sop <= 1'b0;
      b_fin <= 1'b0;
      b_bad <= 1'b0;
      b_fcs <= 1'b0;
      b_drop <= 1'b0;
      b_kind <= 3'h0;
   end else if (a_v && !absorb) begin
      b_data <= a_data;
      b_cnt <= (a_fin && f_strip) ? a_cnt - FCSB : a_cnt;
      b_v <= 1'b1;
      b_sop <= a_sop;
      b_fin <= a_fin;
      b_bad <= a_bad;
      b_fcs <= fcs_bad_now;
      b_drop <= f_drop;
      b_kind <= f_kind;
   end else if (emit) begin
      b_v <= 1'b0;
   end
end

// Registered client outputs, all on the one receive clock
always @(posedge clk_in) begin
   if (srst_in) begin
      rx_data_out <= {DW{1'b0}};
      rx_valid_out <= 1'b0;
      rx_sop_out <= 1'b0;
      rx_eop_out <= 1'b0;
      rx_empty_out <= 6'h0;
      rx_error_out <= 2'h0;
      rx_fcs_error_out <= 1'b0;
      rx_fcs_valid_out <= 1'b0;
      rx_ctrl_kind_out <= 3'h0;
      p_fe <= 1'b0;
      p_fv <= 1'b0;
      cnt_malformed <= 8'h0;
      cnt_fcs <= 8'h0;
   end else begin
      p_fe <= fe_now;
      p_fv <= fv_now;
      if (emit) begin
         rx_data_out <= b_data;
         rx_valid_out <= !b_drop;
         rx_sop_out <= b_sop && !b_drop;
         rx_eop_out <= eop_now && !b_drop;
         rx_empty_out <= eop_now ? WB[5:0] - kept[5:0] : 6'h0;
         rx_ctrl_kind_out <= b_kind;
      end else begin
         // Custom stream forwards idle words; gap bytes sharing a frame word are lost
         rx_data_out <= hold_data;
         rx_valid_out <= CUSTOM_IF != 0 && !hold_act;
         rx_sop_out <= 1'b0;
         rx_eop_out <= 1'b0;
         rx_empty_out <= 6'h0;
         rx_ctrl_kind_out <= 3'h0;
      end
      rx_error_out[0] <= bad_now;
      rx_error_out[1] <= EOP_ALIGN != 0 ? fe_now : p_fe;
      rx_fcs_error_out <= EOP_ALIGN != 0 ? fe_now : p_fe;
      rx_fcs_valid_out <= EOP_ALIGN != 0 ? fv_now : p_fv;
      if (bad_now) cnt_malformed <= cnt_malformed + 8'h1;
      if (fe_now) cnt_fcs <= cnt_fcs + 8'h1;
   end
end

endmodule // rxfp_rx_mac
`default_nettype wire

/* File: rxfp_sink.sv */
// Client sink model: gathers each packet, reports length, hash and flags.
// Assumes the 64-byte client word; it never stalls the stream.
`timescale 1ns/100ps
`default_nettype none
module rxfp_sink (
   // Clock and reset
   input wire logic clk_in,
   input wire logic srst_in,
   // Client stream
   input wire logic [511:0] data_in,
   input wire logic valid_in,
   input wire logic sop_in,
   input wire logic eop_in,
   input wire logic [5:0] empty_in,
   input wire logic [5:0] flags_in,
   // Packet summary
   output logic done_out,
   output logic [15:0] len_out,
   output logic [31:0] hash_out,
   output logic [5:0] sum_flags_out
);
   logic [15:0] n;
   logic [31:0] h;
   ////////////////////////////////////////
   // Takes a word every valid cycle, since no stall path exists
   always @(posedge clk_in) begin
      done_out <= 1'b0;
      if (!srst_in && valid_in) begin
         if (sop_in) begin
            n = 16'h0;
            h = 32'h0;
         end
         for (int i = 0; i < 64; i++) begin
            if (!eop_in || i < 64 - empty_in) begin
               h = h * 31 + data_in[8*(63-i)+:8];
               n = n + 16'h1;
            end
         end
         if (eop_in) begin
            done_out <= 1'b1;
            len_out <= n;
            hash_out <= h;
            sum_flags_out <= flags_in;
         end
      end
   end
endmodule // rxfp_sink
`default_nettype wire

/* File: tb_top.sv */
// Testbench: random frames over the link, register reads, packets checked.
// Assumes the default build: 64-byte word, preamble stripped, aligned end.
`timescale 1ns/100ps
`default_nettype none
`include "rxfp_consts.vh"
module tb_top;
   typedef struct packed {logic [15:0] len; logic [31:0] hash; logic [5:0] flags;} rxfp_note_t;
   logic clk_in = 1'b0;
   logic srst_in = 1'b1;
   logic [511:0] lnk_data_in = {64{8'h07}};
   logic [63:0] lnk_ctrl_in = '1;
   logic [3:0] reg_addr_in = 4'h0;
   logic [31:0] reg_wdata_in = 32'h0;
   logic reg_wr_in = 1'b0;
   logic reg_rd_in = 1'b0;
   logic rd_d = 1'b0;
   wire [31:0] reg_rdata_out, hash;
   wire [511:0] rx_data_out;
   wire [5:0] rx_empty_out, sflags;
   wire [1:0] rx_error_out;
   wire [2:0] rx_ctrl_kind_out;
   wire [15:0] len, quanta;
   wire [7:0] pclass;
   wire rx_valid_out, rx_sop_out, rx_eop_out, rx_fcs_error_out, rx_fcs_valid_out, pause_std_out, pfc_req_out, done;
   rxfp_note_t exp_q[$];
   rxfp_note_t exp;
   logic [31:0] rq[$];
   logic [8:0] strm[$];
   logic [7:0] fr[$];
   int num_errors = 0;
   int compares = 0;
   int cycles = 0;
   int lens [5] = '{64, 124, 125, 130, 200};
   logic [15:0] ops [3] = '{16'h0001, 16'h0101, 16'h0002};
   logic [2:0] kinds [3] = '{`RXFP_KIND_STD, `RXFP_KIND_PFC, `RXFP_KIND_OTHER};
   rxfp_rx_mac dut (
      .clk_in(clk_in), .srst_in(srst_in), .lnk_data_in(lnk_data_in), .lnk_ctrl_in(lnk_ctrl_in),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out), .rx_data_out(rx_data_out), .rx_valid_out(rx_valid_out),
      .rx_sop_out(rx_sop_out), .rx_eop_out(rx_eop_out), .rx_empty_out(rx_empty_out),
      .rx_error_out(rx_error_out), .rx_fcs_error_out(rx_fcs_error_out), .rx_fcs_valid_out(rx_fcs_valid_out),
      .rx_ctrl_kind_out(rx_ctrl_kind_out), .pause_std_out(pause_std_out), .pause_quanta_out(quanta),
      .pfc_req_out(pfc_req_out), .pfc_class_out(pclass)
   );
   rxfp_sink u_sink (
      .clk_in(clk_in), .srst_in(srst_in), .data_in(rx_data_out), .valid_in(rx_valid_out),
      .sop_in(rx_sop_out), .eop_in(rx_eop_out), .empty_in(rx_empty_out),
      .flags_in({rx_error_out, rx_fcs_error_out, rx_ctrl_kind_out}), .done_out(done),
      .len_out(len), .hash_out(hash), .sum_flags_out(sflags)
   );
   always #20 clk_in = ~clk_in;
   ////////////////////////////////////////
   task automatic check(input logic [63:0] seen, input logic [63:0] want, input string what);
      compares++;
      if (seen !== want) begin
         num_errors++;
         $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, want);
      end
   endtask
   task automatic close_out;
      check(exp_q.size(), 0, "packets never delivered");
      $display("compares %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Idle cycle after each access keeps strobes from being driven twice at one edge
   task automatic rw(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [31:0] e);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= wr;
      reg_rd_in <= ~wr;
      if (!wr) rq.push_back(e);
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
      reg_rd_in <= 1'b0;
      @(posedge clk_in);
   endtask
   task automatic mk(input int n, input logic [31:0] tag);
      fr = {};
      for (int i = 0; i < n - 4; i++) fr.push_back(8'($urandom));
      {fr[12], fr[13], fr[14], fr[15]} = tag;
   endtask
   // Modes: 0 good, 1 bad checksum, 2 error character, 3 bad delimiter
   task automatic send(input int mode, input logic strip, input logic [2:0] kind);
      logic [31:0] c;
      logic [31:0] h;
      int n;
      c = `RXFP_CRC_INIT;
      foreach (fr[i]) begin
         c = c ^ fr[i];
         repeat (8) c = c[0] ? (c >> 1) ^ `RXFP_CRC_POLY : c >> 1;
      end
      c = ~c;
      for (int i = 0; i < 4; i++) fr.push_back(c[8*i+:8]);
      if (mode == 1) fr[20] = fr[20] ^ 8'h01;
      strm = {9'h1fb};
      repeat (6) strm.push_back(9'h055);
      strm.push_back({1'b0, mode == 3 ? 8'hd4 : `RXFP_SFD});
      foreach (fr[i]) strm.push_back({1'b0, fr[i]});
      strm.push_back(mode == 2 ? 9'h1fe : 9'h1fd);
      strm.push_back(mode == 2 ? 9'h1fd : 9'h107);
      while (strm.size() % 64 != 0) strm.push_back(9'h107);
      repeat (64) strm.push_back(9'h107);
      n = strip ? fr.size() - 4 : fr.size();
      h = 32'h0;
      for (int i = 0; i < n; i++) h = h * 31 + fr[i];
      if (mode != 3)
         exp_q.push_back('{mode == 2 ? 16'h0 : n[15:0], mode == 2 ? 32'h0 : h,
            {mode == 1 ? 3'b101 : mode == 2 ? 3'b111 : 3'b000, kind}});
      while (strm.size() > 0) begin
         for (int i = 0; i < 64; i++) {lnk_ctrl_in[63-i], lnk_data_in[8*(63-i)+:8]} <= strm.pop_front();
         @(posedge clk_in);
      end
   endtask
   ////////////////////////////////////////
   always @(posedge clk_in) begin
      rd_d <= reg_rd_in;
      cycles++;
      if (cycles == 2000) begin
         num_errors++;
         close_out;
      end
   end
   // Results sampled mid-cycle, once the edge's updates have landed
   always @(negedge clk_in) begin
      if (rd_d) check(reg_rdata_out, rq.pop_front(), "register read");
      if (done === 1'b1) begin
         if (exp_q.size() == 0) begin
            check(64'h1, 64'h0, "packet not expected");
         end else begin
            exp = exp_q.pop_front();
            check({exp.len == 0 ? 48'h0 : {len, hash}, sflags}, exp, "packet");
         end
      end
   end
   initial begin
      void'($urandom(32'h2f09));
      repeat (10) @(posedge clk_in);
      srst_in <= 1'b0;
      @(posedge clk_in);
      rw(1'b0, `RXFP_REG_STRIP, 32'h0, 32'h1);
      rw(1'b0, 4'hc, 32'h0, 32'h0);
      foreach (lens[i]) begin
         mk(lens[i], 32'h08000000);
         send(0, 1'b1, 3'h0);
      end
      mk(72, 32'h08000000);
      send(1, 1'b1, 3'h0);
      mk(80, 32'h08000000);
      send(2, 1'b1, 3'h0);
      mk(72, 32'h08000000);
      send(3, 1'b1, 3'h0);
      for (int k = 0; k < 3; k++) begin
         mk(64, {16'h8808, ops[k]});
         send(0, 1'b1, kinds[k]);
      end
      rw(1'b1, `RXFP_REG_STRIP, 32'h0, 32'h0);
      rw(1'b0, `RXFP_REG_STRIP, 32'h0, 32'h0);
      mk(124, 32'h08000000);
      send(0, 1'b0, 3'h0);
      mk(72, 32'h08000000);
      send(1, 1'b0, 3'h0);
      rw(1'b0, `RXFP_REG_PAUSE, 32'h0, 32'h000001ff);
      rw(1'b0, `RXFP_REG_STAT, 32'h0, 32'h00000301);
      repeat (20) @(posedge clk_in);
      @(negedge clk_in);
      check({pclass, quanta}, 64'h0, "pause outputs");
      close_out;
   end
endmodule // tb_top
`default_nettype wire
